// ===== ais_defs.vh
// Overview of operation
// - Each channel keeps separate filter and hysteresis state.
// - Filter first, hysteresis sees only filtered values.
// - Output is ((N-1)*previous plus sample) over N.
// - N is two to the order; divide by shifting.
// - Order range 0..16, three after reset.
// - Samples inside plus/minus window are discarded.
// - Sample outside window becomes reference and output.
// - Window 0..10 V in counts, 0.01 V default.
`ifndef AIS_DEFS_VH
`define AIS_DEFS_VH
// Channel count and channel index width
`define AIS_CH_NUM 4
`define AIS_CH_W 2
// Sample width: 12 bit converter, 0..10 V full scale
`define AIS_SAMPLE_W 12
// Filter order field width, reset value and highest legal order
`define AIS_ORDER_W 5
`define AIS_ORDER_RST 5'h03
`define AIS_ORDER_MAX 5'h10
// Hysteresis half window: 0.01 V is about 4 counts of 2.44 mV, 10 V is full scale
`define AIS_HYST_RST 12'h004
`define AIS_HYST_MAX 12'hFFF
// Width of the shift accumulator: sample plus largest shift plus sign room
`define AIS_ACC_W 29
// Input FIFO shape
`define AIS_FIFO_DEPTH 16
`define AIS_FIFO_AW 4
`endif

// ===== ais_smooth.v
`timescale 1ns/10ps
`include "ais_defs.vh"

// Sample FIFO, flip-flop storage, registered ready toward the writer
module ais_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Write side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output reg in_ready,
  // Read side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  localparam [AW:0] FULL = DEPTH;
  localparam [AW:0] ONE = 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wr_ptr; // Next slot to write
  reg [AW-1:0] rd_ptr; // Oldest word
  reg [AW:0] count; // Words held
  reg [AW:0] next_count;
  wire push;
  wire pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];

  // Occupancy after this cycle
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + ONE;
    end else if (pop && !push) begin
      next_count = count - ONE;
    end
  end

  // Pointers, count and ready; ready is registered so it comes from a flop
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      count <= next_count;
      // Ready drops only when truly full, so no word is ever lost
      in_ready <= (next_count != FULL);
    end
  end

  // Data storage needs no reset
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// Per-channel lowpass plus hysteresis conditioning of analog samples
module ais_smooth (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Samples from the converter
  input wire sample_valid,
  input wire [`AIS_CH_W-1:0] sample_chan,
  input wire [`AIS_SAMPLE_W-1:0] sample_data,
  output wire sample_ready,
  // Configuration strobe
  input wire cfg_valid,
  input wire [`AIS_ORDER_W-1:0] cfg_order,
  input wire [`AIS_SAMPLE_W-1:0] cfg_hyst,
  // Conditioned values toward readout
  input wire out_ready,
  output reg out_valid,
  output reg [`AIS_CH_W-1:0] out_chan,
  output reg [`AIS_SAMPLE_W-1:0] out_value,
  output reg [`AIS_SAMPLE_W-1:0] out_filtered,
  output reg out_changed,
  // Active settings
  output reg [`AIS_ORDER_W-1:0] smoothing_shift_setting,
  output reg [`AIS_SAMPLE_W-1:0] hyst_amount
);
  localparam FW = `AIS_CH_W + `AIS_SAMPLE_W;
  localparam SW = `AIS_SAMPLE_W;

  // One filter step: ((2^k - 1) * y + x) >> k, done with a shift and subtract
  function [`AIS_SAMPLE_W-1:0] ais_lpf;
    input [`AIS_SAMPLE_W-1:0] y;
    input [`AIS_SAMPLE_W-1:0] x;
    input [`AIS_ORDER_W-1:0] k;
    reg [`AIS_ACC_W-1:0] acc;
    begin
      acc = ({{(`AIS_ACC_W-SW){1'b0}}, y} << k) - {{(`AIS_ACC_W-SW){1'b0}}, y}
            + {{(`AIS_ACC_W-SW){1'b0}}, x};
      acc = acc >> k;
      // Result never exceeds the larger input, so the low bits are exact
      ais_lpf = acc[`AIS_SAMPLE_W-1:0];
    end
  endfunction

  wire [FW-1:0] fifo_data; // Channel and sample from the FIFO
  wire fifo_valid; // FIFO holds a sample
  wire pop; // Sample taken for processing this cycle
  wire [`AIS_CH_W-1:0] ch; // Channel of the popped sample
  wire [SW-1:0] x; // Raw sample value
  wire [SW*`AIS_CH_NUM-1:0] filt_bus; // All filter states
  wire [SW*`AIS_CH_NUM-1:0] ref_bus; // All hysteresis references
  wire [`AIS_CH_NUM-1:0] primed; // Channel has seen its first sample
  reg [SW-1:0] f_new; // Filtered value for this sample
  reg [SW-1:0] diff; // Distance from reference
  reg take; // Filtered value becomes the new active value
  reg [SW-1:0] cur_f;
  reg [SW-1:0] cur_r;
  reg cur_p;

  // Samples are buffered so a stalled readout back-pressures the converter
  ais_fifo #(
    .WIDTH(FW),
    .DEPTH(`AIS_FIFO_DEPTH),
    .AW(`AIS_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(sample_valid),
    .in_data({sample_chan, sample_data}),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(pop)
  );

  // Take a new sample when the output slot is free or being read
  assign pop = fifo_valid & (~out_valid | out_ready);
  assign ch = fifo_data[FW-1:SW];
  assign x = fifo_data[SW-1:0];

  // Settings update; an order above the legal range is ignored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smoothing_shift_setting <= `AIS_ORDER_RST;
      hyst_amount <= `AIS_HYST_RST;
    end else if (cfg_valid) begin
      if (cfg_order <= `AIS_ORDER_MAX) begin
        smoothing_shift_setting <= cfg_order;
      end
      if (cfg_hyst <= `AIS_HYST_MAX) begin
        hyst_amount <= cfg_hyst;
      end
    end
  end

  // Datapath for the channel whose sample is being processed
  always @* begin
    cur_f = filt_bus[ch*SW +: SW];
    cur_r = ref_bus[ch*SW +: SW];
    cur_p = primed[ch];
    if (!cur_p) begin
      f_new = x;
    end else begin
      f_new = ais_lpf(cur_f, x, smoothing_shift_setting);
    end
    if (f_new > cur_r) begin
      diff = f_new - cur_r;
    end else begin
      diff = cur_r - f_new;
    end
    take = ~cur_p | (diff > hyst_amount);
  end

  // Per-channel state, one independent set of flops for each channel
  genvar i;
  generate
    for (i = 0; i < `AIS_CH_NUM; i = i + 1) begin : g_ch
      reg [SW-1:0] filt; // Filter state
      reg [SW-1:0] refv; // Hysteresis reference
      reg seen; // First sample taken
      assign filt_bus[i*SW +: SW] = filt;
      assign ref_bus[i*SW +: SW] = refv;
      assign primed[i] = seen;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          filt <= {SW{1'b0}};
          refv <= {SW{1'b0}};
          seen <= 1'b0;
        end else if (pop && (ch == i)) begin
          filt <= f_new;
          seen <= 1'b1;
          if (take) begin
            refv <= f_new;
          end
        end
      end
    end
  endgenerate

  // Output slot: holds until the readout accepts it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_chan <= {`AIS_CH_W{1'b0}};
      out_value <= {SW{1'b0}};
      out_filtered <= {SW{1'b0}};
      out_changed <= 1'b0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_chan <= ch;
      out_filtered <= f_new;
      out_changed <= take;
      out_value <= take ? f_new : cur_r;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ===== ais_smooth_checker.sv
`timescale 1ns/10ps
// Watches settings and the output handshake of the conditioning block
module ais_smooth_checker (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Sample side and settings
  input logic sample_ready,
  input logic cfg_valid,
  input logic [4:0] cfg_order,
  input logic [4:0] smoothing_shift_setting,
  input logic [11:0] cfg_hyst,
  input logic [11:0] hyst_amount,
  // Output side
  input logic out_ready,
  input logic out_valid,
  input logic out_changed,
  input logic [1:0] out_chan,
  input logic [11:0] out_value,
  input logic [11:0] out_filtered
);
  // Distance of the filtered value from the held reference
  wire [11:0] gap = out_filtered > out_value ? out_filtered - out_value : out_value - out_filtered;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rst_val_a: assert property ($rose(rstn) |-> sample_ready && smoothing_shift_setting == 5'h03 && hyst_amount == 12'h004)
    else $error("reset settings");
  ord_load_a: assert property (cfg_valid && cfg_order <= 5'h10 |=> smoothing_shift_setting == $past(cfg_order))
    else $error("order not loaded");
  ord_keep_a: assert property (cfg_valid && cfg_order > 5'h10 |=> $stable(smoothing_shift_setting))
    else $error("bad order taken");
  ord_range_a: assert property (smoothing_shift_setting <= 5'h10)
    else $error("order range");
  hyst_load_a: assert property (cfg_valid |=> hyst_amount == $past(cfg_hyst))
    else $error("window not loaded");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable({out_chan, out_value, out_filtered, out_changed}))
    else $error("output moved");
  new_ref_a: assert property (out_valid && out_changed |-> out_value == out_filtered)
    else $error("new reference");
  in_window_a: assert property ($rose(out_valid) && !out_changed && $stable(hyst_amount) |-> gap <= hyst_amount)
    else $error("window kept");
endmodule
bind ais_smooth ais_smooth_checker ais_smooth_checker_inst (.clk, .rstn, .sample_ready, .cfg_valid, .cfg_order,
  .smoothing_shift_setting, .cfg_hyst, .hyst_amount, .out_ready, .out_valid, .out_changed, .out_chan,
  .out_value, .out_filtered);

// ===== ais_readout_model.sv
`timescale 1ns/10ps
// Readout stand-in: prompt, slow or fully stalled
module ais_readout_model (
  input wire clk,
  input wire rstn,
  input wire [1:0] mode,
  output reg out_ready
);
  // Moves off the sampling edge; slow mode refuses at random
  always @(negedge clk or negedge rstn)
    if (!rstn) out_ready <= 1'b0;
    else out_ready <= mode == 2'h0 || (mode == 2'h1 && $urandom % 3 != 0);
endmodule

// ===== ais_smooth_test.sv
`timescale 1ns/10ps
module ais_smooth_test;
  reg clk = 0, rstn = 0, sample_valid = 0, cfg_valid = 0, full = 0;
  reg [1:0] sample_chan = 0, mode = 0;
  reg [11:0] sample_data = 0, cfg_hyst = 0, hy = 12'h004;
  reg [4:0] cfg_order = 0, ord = 5'h03;
  wire sample_ready, out_ready, out_valid, out_changed;
  wire [1:0] out_chan;
  wire [11:0] out_value, out_filtered, hyst_amount;
  wire [4:0] smoothing_shift_setting;
  // Model state per channel, and notes of expected words
  reg [11:0] fy [4], rf [4];
  bit seen [4];
  reg [40:0] acc;
  reg [26:0] q [$];
  int err_total = 0, samples_checked = 0, cyc = 0, i;
  int ords [5] = '{0, 1, 7, 16, 17};
  ais_smooth ais_smooth_inst (
    .clk(clk),
    .rstn(rstn),
    .sample_valid(sample_valid),
    .sample_chan(sample_chan),
    .sample_data(sample_data),
    .sample_ready(sample_ready),
    .cfg_valid(cfg_valid),
    .cfg_order(cfg_order),
    .cfg_hyst(cfg_hyst),
    .out_ready(out_ready),
    .out_valid(out_valid),
    .out_chan(out_chan),
    .out_value(out_value),
    .out_filtered(out_filtered),
    .out_changed(out_changed),
    .smoothing_shift_setting(smoothing_shift_setting),
    .hyst_amount(hyst_amount)
  );
  ais_readout_model ais_readout_model_inst (.clk, .rstn, .mode, .out_ready);
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [26:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Offer one sample, hold it until taken, note the expected word
  task automatic send(input logic [1:0] c, input logic [11:0] x);
    logic [11:0] f, d;
    logic ch;
    @(negedge clk);
    sample_valid = 1;
    sample_chan = c;
    sample_data = x;
    full |= !sample_ready;
    while (!sample_ready) @(negedge clk);
    @(posedge clk);
    acc = ({29'h0, fy[c]} << ord) - fy[c] + x;
    f = seen[c] ? 12'(acc >> ord) : x;
    d = f > rf[c] ? f - rf[c] : rf[c] - f;
    ch = !seen[c] || d > hy;
    if (ch) rf[c] = f;
    fy[c] = f;
    seen[c] = 1;
    q.push_back({c, rf[c], f, ch});
  endtask
  task automatic burst(input int n, input logic [11:0] base);
    for (int k = 0; k < n; k++) send($urandom % 4, base + $urandom % 24);
  endtask
  // Settings change only once all words are out
  task automatic cfg(input logic [4:0] o, input logic [11:0] h);
    @(negedge clk);
    sample_valid = 0;
    while (q.size()) @(negedge clk);
    cfg_valid = 1;
    cfg_order = o;
    cfg_hyst = h;
    @(negedge clk);
    cfg_valid = 0;
    if (o <= 5'h10) ord = o;
    hy = h;
    chk({smoothing_shift_setting, hyst_amount}, {ord, hy});
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Pair each accepted word with the oldest note
  always @(posedge clk)
    if (rstn && out_valid && out_ready)
      chk({out_chan, out_value, out_filtered, out_changed}, q.size() ? q.pop_front() : 'x);
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(70));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1;
    chk({sample_ready, smoothing_shift_setting, hyst_amount}, {1'b1, ord, hy});
    for (i = 0; i < 4; i++) send(i, 12'h3E8 * i + 12'h007);
    burst(40, 12'h800);
    $display("first samples and noise done");
    mode = 1;
    for (i = 0; i < 5; i++) begin
      cfg(ords[i], 12'h004 * i + 12'h001);
      burst(10, 12'h100 * i);
    end
    $display("orders and window sizes done");
    mode = 2;
    fork
      begin
        repeat (60) @(posedge clk);
        mode = 0;
      end
    join_none
    burst(20, 12'hC00);
    // Window edge: order 0 passes samples, a gap of exactly 10 is kept out, 11 is taken
    for (i = 0; i < 3; i++) begin
      cfg(5'h00, 12'h00A);
      send(0, i ? 12'h009 + i : 12'h000);
    end
    $display("window edge done");
    cfg(5'h03, 12'h004);
    chk(full, 1'b1);
    $display("fill and drain done");
    print_verdict;
  end
endmodule
